// ### core/csh_params.svh
// timing constants and counter width for the configuration status handshake
`ifndef CSH_PARAMS_SVH
`define CSH_PARAMS_SVH
`define CSH_CLK_HZ        10000000
`define CSH_POR_SHORT_MS  12
`define CSH_POR_LONG_MS   100
`define CSH_POR_SHORT_CYC ((`CSH_CLK_HZ / 1000) * `CSH_POR_SHORT_MS)
`define CSH_POR_LONG_CYC  ((`CSH_CLK_HZ / 1000) * `CSH_POR_LONG_MS)
`define CSH_POR_W         20
`endif

// ### core/csh_pkg.sv
// types for the configuration status handshake
package csh_pkg;
  typedef enum logic [2:0] {
    CSH_POR    = 3'b000,
    CSH_CONFIG = 3'b001,
    CSH_INIT   = 3'b010,
    CSH_USER   = 3'b011,
    CSH_ERROR  = 3'b100,
    CSH_RESET  = 3'b101
  } csh_state_e;
endpackage

// ### core/csh_sync.sv
// two flip-flop synchroniser for pin inputs
module csh_sync (
  input  wire logic clock_i,
  input  wire logic srst_i,
  input  wire logic rst_val_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;
  logic meta_d;
  logic q_d;

  always_comb begin
    meta_d = d_i;
    q_d    = meta_q;
  end

  // reset level fixed by caller tie-off; kept synchronous so no async load issue
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      meta_q <= rst_val_i;
      q_o    <= rst_val_i;
    end else begin
      meta_q <= meta_d;
      q_o    <= q_d;
    end
  end
endmodule

// ### core/csh_core.sv
// configuration status line handshake controller
// Summary of operation
// R1: hold status line low from power-up until power-on delay elapses.
// R2: pull status line low when configuration error is detected.
// R3: external low on status during config or init enters error state.
// R4: in user mode ignore status line; keep configuration.
// R5: attached configuration source retries when it sees status low.
// R6: outside party requests reconfiguration via request input, not status line.
// R7: attempt before power-on delay ends fails; status stays low meanwhile.
// R8: status released high after delay starts a new attempt to completion.
// R9: request low in user mode resets device; return high reconfigures.
// R10: power-on delay about 12 ms with select high, 100 ms low.
// R11: status line only driven low or released, never driven high.
`include "csh_params.svh"
module csh_core #(
  parameter int unsigned POR_SHORT_CYC = `CSH_POR_SHORT_CYC,
  parameter int unsigned POR_LONG_CYC  = `CSH_POR_LONG_CYC
) (
  input  wire logic          clock_i,
  input  wire logic          srst_i,
  input  wire logic          por_sel_i,
  input  wire logic          config_req_n_i,
  input  wire logic          config_status_n_i,
  output logic               config_status_n_o,
  output logic               config_status_n_oe_o,
  input  wire logic          cfg_error_i,
  input  wire logic          cfg_done_i,
  input  wire logic          init_done_i,
  output logic               cfg_start_o,
  output logic               cfg_active_o,
  output logic               user_mode_o,
  output logic               error_o,
  output csh_pkg::csh_state_e state_o
);
  import csh_pkg::*;

  logic                  status_s;
  logic                  req_s;
  logic                  por_sel_s;
  csh_state_e            state_q, state_d;
  logic [`CSH_POR_W-1:0] cnt_q, cnt_d;
  logic                  drive_q, drive_d;
  logic                  start_q, start_d;

  csh_sync u_sync_status (
    .clock_i   (clock_i),
    .srst_i    (srst_i),
    .rst_val_i (1'b1),
    .d_i       (config_status_n_i),
    .q_o       (status_s)
  );
  csh_sync u_sync_req (
    .clock_i   (clock_i),
    .srst_i    (srst_i),
    .rst_val_i (1'b1),
    .d_i       (config_req_n_i),
    .q_o       (req_s)
  );
  csh_sync u_sync_sel (
    .clock_i   (clock_i),
    .srst_i    (srst_i),
    .rst_val_i (1'b1),
    .d_i       (por_sel_i),
    .q_o       (por_sel_s)
  );

  function automatic logic [`CSH_POR_W-1:0] por_len(input logic sel);
    por_len = sel ? POR_SHORT_CYC[`CSH_POR_W-1:0]
                  : POR_LONG_CYC[`CSH_POR_W-1:0]; // R10
  endfunction

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    drive_d = drive_q;
    start_d = 1'b0;
    case (state_q)
      CSH_POR: begin
        // R1 R7: line held low, any attempt meanwhile cannot proceed
        drive_d = 1'b1;
        if (cnt_q >= por_len(por_sel_s) - `CSH_POR_W'(1)) begin
          drive_d = 1'b0;
          cnt_d   = '0;
          state_d = CSH_RESET;
        end else begin
          cnt_d = cnt_q + `CSH_POR_W'(1);
        end
      end
      CSH_RESET: begin
        // wait for released line and high request before a new attempt
        drive_d = 1'b0;
        if (status_s && req_s) begin
          start_d = 1'b1; // R8
          state_d = CSH_CONFIG;
        end
      end
      CSH_CONFIG: begin
        if (!req_s) begin
          state_d = CSH_RESET;
        end else if (cfg_error_i) begin
          drive_d = 1'b1; // R2
          state_d = CSH_ERROR;
        end else if (!status_s) begin
          state_d = CSH_ERROR; // R3
        end else if (cfg_done_i) begin
          state_d = CSH_INIT;
        end
      end
      CSH_INIT: begin
        if (!req_s) begin
          state_d = CSH_RESET;
        end else if (!status_s) begin
          state_d = CSH_ERROR; // R3
        end else if (init_done_i) begin
          state_d = CSH_USER;
        end
      end
      CSH_USER: begin
        // status line not looked at here: configuration kept
        if (!req_s) begin
          state_d = CSH_RESET; // R4 R9
        end
      end
      CSH_ERROR: begin
        // pulse low one cycle if entered on cfg_error_i, then release so the source retries
        if (drive_q) begin
          drive_d = 1'b0; // R5
        end else begin
          state_d = CSH_RESET;
        end
      end
      default: begin
        state_d = CSH_POR;
        cnt_d   = '0;
        drive_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_q <= CSH_POR;
      cnt_q   <= '0;
      drive_q <= 1'b1;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      drive_q <= drive_d;
      start_q <= start_d;
    end
  end

  assign config_status_n_o    = 1'b0; // R11
  assign config_status_n_oe_o = drive_q;
  assign cfg_start_o          = start_q;
  assign cfg_active_o         = (state_q == CSH_CONFIG) || (state_q == CSH_INIT);
  assign user_mode_o          = (state_q == CSH_USER);
  assign error_o              = (state_q == CSH_ERROR);
  assign state_o              = state_q;
endmodule

// ### verif/csh_monitor.sv
// checker for the status line handshake
module csh_monitor
  import csh_pkg::*;
(
  input wire logic          clock_i,
  input wire logic          srst_i,
  input wire logic          config_req_n_i,
  input wire logic          config_status_n_i,
  input wire logic          config_status_n_o,
  input wire logic          config_status_n_oe_o,
  input wire logic          cfg_error_i,
  input wire logic          cfg_start_o,
  input wire logic          cfg_active_o,
  input wire logic          user_mode_o,
  input wire logic          error_o,
  input csh_pkg::csh_state_e state_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  drive_low_a: assert property (config_status_n_o == 1'b0)
    else $error("line driven high");
  por_hold_a: assert property (state_o == CSH_POR |-> config_status_n_oe_o)
    else $error("line released in power-on wait");
  start_pulse_a: assert property (cfg_start_o |=> !cfg_start_o)
    else $error("start longer than one cycle");
  start_cfg_a: assert property (cfg_start_o |-> state_o == CSH_CONFIG)
    else $error("start outside configuration");
  err_drive_a: assert property (state_o == CSH_CONFIG && cfg_error_i |-> ##[1:2] config_status_n_oe_o)
    else $error("error not reported on line");
  err_short_a: assert property (config_status_n_oe_o && state_o != CSH_POR |=> !config_status_n_oe_o)
    else $error("error pulse too long");
  ext_err_a: assert property (cfg_active_o && !config_status_n_i && !config_status_n_oe_o
    |-> ##[1:4] error_o)
    else $error("outside low not taken as error");
  user_keep_a: assert property (user_mode_o && config_req_n_i && $past(config_req_n_i)
    && $past(config_req_n_i, 2) |=> user_mode_o)
    else $error("user mode lost");
  user_exit_a: assert property ($fell(user_mode_o) |-> state_o == CSH_RESET)
    else $error("user mode left without reset");
  cover property (cfg_start_o);
  cover property (error_o);
  cover property (user_mode_o);
endmodule
bind csh_core csh_monitor u_mon (.*);

// ### verif/csh_host.sv
// outside host sharing the status line through a pull-up
module csh_host (
  input  wire logic clock_i,
  input  wire logic dev_oe_i,
  input  wire logic pull_low_i,
  output logic      line_o,
  output int        retries_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // only pulled low, high comes from the resistor
  assign line_o = !(dev_oe_i || pull_low_i);
  initial retries_o = 0;
  // each low seen restarts the data send
  always @(posedge clock_i) if ($fell(line_o)) retries_o <= retries_o + 1;
endmodule

// ### verif/testbench.sv
// self-checking bench for the status handshake controller
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import csh_pkg::*;
  logic clock_i = 0, srst_i = 1, por_sel_i = 1, config_req_n_i = 1, pull_low = 0;
  logic cfg_error_i = 0, cfg_done_i = 0, init_done_i = 0, config_status_n_i;
  logic config_status_n_o, config_status_n_oe_o, cfg_start_o, cfg_active_o;
  logic user_mode_o, error_o;
  csh_state_e state_o;
  int n_fail = 0, comparisons = 0, retries, r0, c;
  csh_core #(.POR_SHORT_CYC(20), .POR_LONG_CYC(40)) dut (.*);
  csh_host host (.clock_i, .dev_oe_i(config_status_n_oe_o), .pull_low_i(pull_low),
    .line_o(config_status_n_i), .retries_o(retries));
  always #50 clock_i = ~clock_i;
  task step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task automatic wait_hi(ref logic s);
    for (int i = 0; i < 60 && s !== 1'b1; i++) step(1);
  endtask
  task t_por(input logic sel, input int n);
    por_sel_i = sel;
    srst_i = 1;
    step(2);
    srst_i = 0;
    c = 0;
    do begin
      step(1);
      c++;
      if (c == 3) chk("line", 0, config_status_n_i);
    end while (config_status_n_oe_o === 1'b1 && c < 100);
    chk("por cycles", n, c);
    chk("released line", 1, config_status_n_i);
    wait_hi(cfg_start_o);
    chk("start", 1, cfg_start_o);
    $display("power-on test finished");
  endtask
  task t_err;
    r0 = retries;
    cfg_error_i = 1;
    step(1);
    cfg_error_i = 0;
    wait_hi(error_o);
    chk("error", 1, error_o);
    chk("error line", 0, config_status_n_i);
    wait_hi(cfg_start_o);
    chk("retry", 1, retries > r0);
    pull_low = 1;
    wait_hi(error_o);
    chk("outside error", 1, error_o);
    pull_low = 0;
    wait_hi(cfg_start_o);
    cfg_done_i = 1;
    step(1);
    cfg_done_i = 0;
    chk("init state", CSH_INIT, state_o);
    pull_low = 1;
    wait_hi(error_o);
    chk("init error", 1, error_o);
    pull_low = 0;
    wait_hi(cfg_start_o);
    $display("error test finished");
  endtask
  task t_user;
    cfg_done_i = 1;
    step(1);
    cfg_done_i = 0;
    chk("active", 1, cfg_active_o);
    init_done_i = 1;
    step(1);
    init_done_i = 0;
    wait_hi(user_mode_o);
    pull_low = 1;
    step(6);
    chk("user kept", 1, user_mode_o);
    chk("user active", 0, cfg_active_o);
    pull_low = 0;
    config_req_n_i = 0;
    step(4);
    chk("reset", CSH_RESET, state_o);
    config_req_n_i = 1;
    wait_hi(cfg_start_o);
    chk("restart", 1, cfg_start_o);
    config_req_n_i = 0;
    step(4);
    chk("abort", CSH_RESET, state_o);
    config_req_n_i = 1;
    wait_hi(cfg_start_o);
    chk("abort restart", 1, cfg_start_o);
    $display("user test finished");
  endtask
  task print_verdict;
    $display("%0d compared, %0d failed", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    t_por(1'b1, 20);
    t_err;
    t_user;
    t_por(1'b0, 40);
    print_verdict;
  end
  initial begin
    #100000;
    n_fail++;
    print_verdict;
  end
endmodule
